// file: design/boot_cfg_consts.vh
// field positions, reset values and register offsets for the boot config
// decoder; included by two of the three design files of that block
`ifndef BOOT_CFG_CONSTS_VH
`define BOOT_CFG_CONSTS_VH
// config word zero fields
`define WPROT_MSB 19
`define WPROT_LSB 12
`define WPROT_OFF 8'hff
`define PAIR_SEL_BIT 3
`define DBG_MSB 1
`define DBG_LSB 0
`define DBG_ON 2'b10
`define DBG_OFF 2'b11
// config word one fields
`define PBDIV_MSB 13
`define PBDIV_LSB 12
`define CLKOUT_BIT 10
`define POSC_MSB 9
`define POSC_LSB 8
`define POSC_OFF 2'b11
`define POSC_EXT 2'b00
`define TWOSPD_BIT 7
`define SOSC_BIT 5
`define OSCSEL_MSB 2
`define OSCSEL_LSB 0
`define OSCSEL_PRI 3'b010
// reserved positions that must read as ones
`define W0_RSVD_MASK 32'h00000ff4
`define W1_RSVD_MASK 32'h00000858
// flash protect region
`define FLASH_BASE 32'hbd000000
`define FLASH_PAGE_SHIFT 12
// apb register offsets
`define REG_WORD0 12'h000
`define REG_WORD1 12'h004
`define REG_STATUS 12'h008
`define REG_DECODE 12'h00c
`define REG_LIMIT 12'h010
`define REG_CTRL 12'h014
`endif

// file: design/cfg_word_fetch.v
// reads both configuration words once after reset
// assumes a storage port answering a request with a valid pulse
`timescale 1ns/1ps
module cfg_word_fetch (
  input wire pclk,
  input wire presetn,
  output wire rd_req,
  output wire rd_sel,
  input wire rd_valid,
  input wire [31:0] rd_data,
  output reg [31:0] word0_ff,
  output reg [31:0] word1_ff,
  output reg done_ff
);
  localparam ST_W0 = 2'd0;
  localparam ST_W1 = 2'd1;
  localparam ST_DONE = 2'd2;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  // =====================================
  // fetch sequence
  assign rd_req = (state_ff != ST_DONE);
  assign rd_sel = (state_ff == ST_W1);
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_W0: if (rd_valid) nxt_state = ST_W1;
      ST_W1: if (rd_valid) nxt_state = ST_DONE;
      default: nxt_state = ST_DONE;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_W0;
      word0_ff <= 32'hffffffff;
      word1_ff <= 32'hffffffff;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_W0 && rd_valid) begin
        word0_ff <= rd_data;
      end
      if (state_ff == ST_W1 && rd_valid) begin
        word1_ff <= rd_data;
        done_ff <= 1'b1;
      end
    end
  end
endmodule

// file: design/pb_clock_div.v
// peripheral bus clock enable: one pulse per 1, 2, 4 or 8 clocks
// assumes the divisor code is steady after start-up
`timescale 1ns/1ps
`include "boot_cfg_consts.vh"
module pb_clock_div (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [1:0] div_code,
  output reg tick_ff
);
  reg [2:0] cnt_ff;
  wire [2:0] last;
  // =====================================
  // divider
  assign last = (3'd1 << div_code) - 3'd1;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 3'd0;
      tick_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff <= 3'd0;
      tick_ff <= 1'b0;
    end else if (cnt_ff >= last) begin
      cnt_ff <= 3'd0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 3'd1;
      tick_ff <= 1'b0;
    end
  end
endmodule

// file: design/boot_config_word_decode.v
// decodes the two boot configuration words into control outputs
// assumes storage answers reads and software uses the apb port
//
// Behaviour
// - protect field is complement of page count
// - block writes inside protected low flash region
// - bit set selects second debug pin pair
// - debugger enabled only for code 10
// - code protect forces debugger field to 11
// - peripheral clock is system clock over 1/2/4/8
// - clock out only when primary off or external
// - primary oscillator mode from two-bit field
// - two-speed start-up follows switchover bit
// - secondary oscillator follows its enable bit
// - initial oscillator from three-bit code
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "boot_cfg_consts.vh"
module boot_config_word_decode (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire cfg_rd_req,
  output wire cfg_rd_sel,
  input wire cfg_rd_valid,
  input wire [31:0] cfg_rd_data,
  input wire code_protect,
  input wire flash_wr_req,
  input wire [31:0] flash_wr_addr,
  output wire flash_wr_block,
  output reg cfg_ready_ff,
  output reg debug_pair_select_ff,
  output reg debugger_enable_ff,
  output reg [1:0] debug_field_ff,
  output reg [1:0] periph_clock_divisor_ff,
  output wire periph_bus_clock_tick,
  output reg clock_out_enable_ff,
  output reg [1:0] primary_osc_mode_ff,
  output reg two_speed_startup_enable_ff,
  output reg secondary_osc_enable_ff,
  output reg [2:0] initial_osc_select_ff,
  output reg [31:0] protect_limit_ff,
  output reg protect_on_ff,
  output reg rsvd_err_ff,
  output reg osc_conflict_ff
);
  wire [31:0] word0;
  wire [31:0] word1;
  wire fetch_done;
  reg done_d_ff;
  reg cp_s1_ff;
  reg cp_s2_ff;
  reg clkdiv_run_ff;
  reg [31:0] blocked_cnt_ff;
  wire [7:0] prot_n;
  wire [7:0] pages;
  wire [1:0] posc;
  wire [1:0] dbg_raw;
  wire load;
  wire apb_wr;
  wire apb_rd;
  wire wr_hit;
  wire prot_hit;
  // =====================================
  // start-up fetch
  cfg_word_fetch u_fetch (
    .pclk(pclk),
    .presetn(presetn),
    .rd_req(cfg_rd_req),
    .rd_sel(cfg_rd_sel),
    .rd_valid(cfg_rd_valid),
    .rd_data(cfg_rd_data),
    .word0_ff(word0),
    .word1_ff(word1),
    .done_ff(fetch_done)
  );
  // =====================================
  // synchronise code protect level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp_s1_ff <= 1'b0;
      cp_s2_ff <= 1'b0;
    end else begin
      cp_s1_ff <= code_protect;
      cp_s2_ff <= cp_s1_ff;
    end
  end
  // =====================================
  // field decode
  assign prot_n = word0[`WPROT_MSB:`WPROT_LSB];
  assign pages = ~prot_n;
  assign posc = word1[`POSC_MSB:`POSC_LSB];
  assign dbg_raw = word0[`DBG_MSB:`DBG_LSB];
  assign load = fetch_done & ~done_d_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_d_ff <= 1'b0;
      cfg_ready_ff <= 1'b0;
      debug_pair_select_ff <= 1'b0;
      debugger_enable_ff <= 1'b0;
      debug_field_ff <= `DBG_OFF;
      periph_clock_divisor_ff <= 2'b00;
      clock_out_enable_ff <= 1'b0;
      primary_osc_mode_ff <= `POSC_OFF;
      two_speed_startup_enable_ff <= 1'b0;
      secondary_osc_enable_ff <= 1'b0;
      initial_osc_select_ff <= 3'b000;
      protect_limit_ff <= 32'h00000000;
      protect_on_ff <= 1'b0;
      rsvd_err_ff <= 1'b0;
      osc_conflict_ff <= 1'b0;
    end else begin
      done_d_ff <= fetch_done;
      if (load) begin
        cfg_ready_ff <= 1'b1;
        debug_pair_select_ff <= word0[`PAIR_SEL_BIT];
        if (cp_s2_ff) begin
          debug_field_ff <= `DBG_OFF;
          debugger_enable_ff <= 1'b0;
        end else begin
          debug_field_ff <= dbg_raw;
          debugger_enable_ff <= (dbg_raw == `DBG_ON);
        end
        periph_clock_divisor_ff <= word1[`PBDIV_MSB:`PBDIV_LSB];
        clock_out_enable_ff <= word1[`CLKOUT_BIT] &
          ((posc == `POSC_OFF) | (posc == `POSC_EXT));
        primary_osc_mode_ff <= posc;
        two_speed_startup_enable_ff <= word1[`TWOSPD_BIT];
        secondary_osc_enable_ff <= word1[`SOSC_BIT];
        initial_osc_select_ff <= word1[`OSCSEL_MSB:`OSCSEL_LSB];
        protect_on_ff <= (prot_n != `WPROT_OFF);
        protect_limit_ff <= `FLASH_BASE +
          ({24'h000000, pages} << `FLASH_PAGE_SHIFT) - 32'h00000001;
        rsvd_err_ff <=
          ((word0 & `W0_RSVD_MASK) != `W0_RSVD_MASK) |
          ((word1 & `W1_RSVD_MASK) != `W1_RSVD_MASK);
        osc_conflict_ff <= (posc == `POSC_OFF) &
          (word1[`OSCSEL_MSB:`OSCSEL_LSB] == `OSCSEL_PRI);
      end
    end
  end
  // =====================================
  // flash write guard
  assign prot_hit = (flash_wr_addr >= `FLASH_BASE) &
    (flash_wr_addr <= protect_limit_ff);
  assign flash_wr_block = flash_wr_req &
    (~cfg_ready_ff | (protect_on_ff & prot_hit));
  // =====================================
  // peripheral clock
  pb_clock_div u_pbdiv (
    .pclk(pclk),
    .presetn(presetn),
    .run(clkdiv_run_ff),
    .div_code(periph_clock_divisor_ff),
    .tick_ff(periph_bus_clock_tick)
  );
  // =====================================
  // apb slave
  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~pwrite;
  assign wr_hit = (paddr == `REG_CTRL);
  assign pslverr = psel & penable & (pwrite ? ~wr_hit :
    ~((paddr == `REG_WORD0) | (paddr == `REG_WORD1) |
      (paddr == `REG_STATUS) | (paddr == `REG_DECODE) |
      (paddr == `REG_LIMIT) | wr_hit));
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkdiv_run_ff <= 1'b1;
      blocked_cnt_ff <= 32'h00000000;
    end else begin
      if (apb_wr && wr_hit) begin
        clkdiv_run_ff <= pwdata[0];
      end
      if (flash_wr_block) begin
        blocked_cnt_ff <= blocked_cnt_ff + 32'h00000001;
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_rd && !penable) begin
      if (paddr == `REG_WORD0) begin
        prdata <= word0;
      end else if (paddr == `REG_WORD1) begin
        prdata <= word1;
      end else if (paddr == `REG_STATUS) begin
        prdata <= {28'h0000000, osc_conflict_ff, rsvd_err_ff,
          protect_on_ff, cfg_ready_ff};
      end else if (paddr == `REG_DECODE) begin
        prdata <= {18'h00000, initial_osc_select_ff,
          secondary_osc_enable_ff, two_speed_startup_enable_ff,
          primary_osc_mode_ff, clock_out_enable_ff,
          periph_clock_divisor_ff, debug_field_ff,
          debugger_enable_ff, debug_pair_select_ff};
      end else if (paddr == `REG_LIMIT) begin
        prdata <= protect_limit_ff;
      end else if (paddr == `REG_CTRL) begin
        prdata <= {31'h00000000, clkdiv_run_ff};
      end else begin
        prdata <= blocked_cnt_ff;
      end
    end
  end
endmodule

// file: dv/boot_cfg_props.sv
// ports checker for the boot config decoder
// assumes a bind to boot_config_word_decode
`timescale 1ns/1ps
module boot_cfg_props (
  input wire pclk,
  input wire presetn,
  input wire cfg_rd_req,
  input wire cfg_rd_sel,
  input wire cfg_rd_valid,
  input wire code_protect,
  input wire flash_wr_req,
  input wire [31:0] flash_wr_addr,
  input wire flash_wr_block,
  input wire cfg_ready_ff,
  input wire debugger_enable_ff,
  input wire [1:0] debug_field_ff,
  input wire clock_out_enable_ff,
  input wire [1:0] primary_osc_mode_ff,
  input wire [2:0] initial_osc_select_ff,
  input wire [31:0] protect_limit_ff,
  input wire protect_on_ff
);
  // ==========================================
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence second_word;
    cfg_rd_req && cfg_rd_valid && cfg_rd_sel;
  endsequence
  ready_time_a: assert property (second_word |-> ##2 cfg_ready_ff)
    else $error("config ready late");
  held_fields_a: assert property (cfg_ready_ff |=> cfg_ready_ff &&
    $stable({debug_field_ff, primary_osc_mode_ff, initial_osc_select_ff}))
    else $error("decoded fields moved");
  debugger_on_a: assert property (cfg_ready_ff |->
    debugger_enable_ff == (debug_field_ff == 2'b10))
    else $error("debugger enable wrong");
  protect_force_a: assert property (cfg_ready_ff && code_protect |->
    debug_field_ff == 2'b11) else $error("debug field not forced");
  clock_out_a: assert property (clock_out_enable_ff |->
    primary_osc_mode_ff inside {2'b11, 2'b00})
    else $error("clock out with crystal mode");
  limit_shape_a: assert property (protect_on_ff |->
    protect_limit_ff[31:20] == 12'hbd0 && protect_limit_ff[11:0] == 12'hfff)
    else $error("protect limit not page end");
  block_inside_a: assert property (cfg_ready_ff && protect_on_ff &&
    flash_wr_req && flash_wr_addr >= 32'hbd000000 &&
    flash_wr_addr <= protect_limit_ff |-> flash_wr_block)
    else $error("protected write let through");
  no_protect_a: assert property (cfg_ready_ff && !protect_on_ff |->
    !flash_wr_block) else $error("write blocked without protect");
  early_block_a: assert property (!cfg_ready_ff && flash_wr_req |->
    flash_wr_block) else $error("write let through before load");
endmodule

// file: dv/cfg_store.sv
// storage model answering config word reads
// assumes the decoder holds its request until a valid pulse
`timescale 1ns/1ps
module cfg_store (
  input wire pclk,
  input wire presetn,
  input wire cfg_rd_req,
  input wire cfg_rd_sel,
  output reg cfg_rd_valid,
  output reg [31:0] cfg_rd_data,
  input wire [31:0] word0,
  input wire [31:0] word1,
  input wire [31:0] lag
);
  reg [31:0] wait_ff;
  // ==========================================
  // answer after lag cycles, scramble otherwise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_rd_valid <= 1'b0;
      cfg_rd_data <= 32'h5a5a5a5a;
      wait_ff <= 32'h0;
    end else if (cfg_rd_req && !cfg_rd_valid && wait_ff >= lag) begin
      cfg_rd_valid <= 1'b1;
      cfg_rd_data <= cfg_rd_sel ? word1 : word0;
      wait_ff <= 32'h0;
    end else begin
      cfg_rd_valid <= 1'b0;
      cfg_rd_data <= ~cfg_rd_data;
      wait_ff <= wait_ff + 32'h1;
    end
  end
endmodule

// file: dv/test_boot_config_word_decode.sv
// bench for the boot config decoder
// assumes the storage model and checker files beside it
`timescale 1ns/1ps
module test_boot_config_word_decode;
  typedef struct packed {logic [7:0] pwp; logic [3:0] w0; logic [13:0] w1;
    logic cp; logic [13:0] dec; logic [31:0] lim;} row_t;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg code_protect = 0, flash_wr_req = 0, err;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 0, flash_wr_addr = 0, word0 = 0, word1 = 0, lag = 0;
  reg [31:0] rd;
  integer fails = 0, compares = 0, cyc = 0, i, n;
  wire [31:0] prdata, cfg_rd_data;
  wire pready, pslverr, cfg_rd_req, cfg_rd_sel, cfg_rd_valid;
  wire flash_wr_block, cfg_ready_ff, periph_bus_clock_tick;
  row_t rows [8];
  boot_config_word_decode dut (.*, .debug_pair_select_ff(),
    .debugger_enable_ff(), .debug_field_ff(), .periph_clock_divisor_ff(),
    .clock_out_enable_ff(), .primary_osc_mode_ff(), .protect_on_ff(),
    .two_speed_startup_enable_ff(), .secondary_osc_enable_ff(),
    .initial_osc_select_ff(), .protect_limit_ff(), .rsvd_err_ff(),
    .osc_conflict_ff());
  cfg_store mdl (.*);
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails = fails + 1;
      give_verdict;
    end
  end
  // ==========================================
  // tasks
  task check(input string what, input [31:0] exp, input [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task boot(input [31:0] a, input [31:0] b, input c, input [31:0] l);
    word0 <= a;
    word1 <= b;
    code_protect <= c;
    lag <= l;
    flash_wr_req <= 1;
    presetn <= 0;
    repeat (5) @(posedge pclk);
    check("early block", 1, flash_wr_block);
    presetn <= 1;
    n = 0;
    while (cfg_ready_ff !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n = n + 1;
    end
    check("ready", 1, cfg_ready_ff);
  endtask
  task ticks(input [31:0] exp);
    n = 0;
    // let a run bit change settle first
    repeat (8) @(posedge pclk);
    repeat (16) begin
      @(posedge pclk);
      n = n + periph_bus_clock_tick;
    end
    check("ticks", exp, n);
  endtask
  task give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================
  // sequence
  initial begin
    rows[0] = '{8'hff, 4'h6, 14'h0c58, 0, 14'h004a, 32'hbd000000};
    rows[1] = '{8'hfe, 4'hf, 14'h1ff9, 0, 14'h0fdd, 32'hbd000fff};
    rows[2] = '{8'hfd, 4'h6, 14'h2d7a, 1, 14'h14ac, 32'hbd001fff};
    rows[3] = '{8'h7f, 4'hd, 14'h3edb, 0, 14'h1b35, 32'hbd07ffff};
    rows[4] = '{8'h00, 4'h4, 14'h087c, 0, 14'h2400, 32'hbd0fefff};
    rows[5] = '{8'hff, 4'h6, 14'h1b5d, 0, 14'h299a, 32'hbd000000};
    rows[6] = '{8'hff, 4'h6, 14'h2afe, 0, 14'h372a, 32'hbd000000};
    rows[7] = '{8'hff, 4'h6, 14'h3c5f, 1, 14'h387c, 32'hbd000000};
    for (i = 0; i < 8; i = i + 1) begin
      boot({12'hfff, rows[i].pwp, 8'hff, rows[i].w0},
        {18'h3ffff, rows[i].w1}, rows[i].cp, i % 3);
      apb(0, 12'h00c, 0);
      check("debug", rows[i].dec[3:0], rd[3:0]);
      check("clocks", rows[i].dec[8:4], rd[8:4]);
      check("osc", rows[i].dec[13:9], rd[13:9]);
      check("decode top", 0, rd[31:14]);
      apb(0, 12'h008, 0);
      check("status", {30'h0, rows[i].pwp != 8'hff, 1'b1}, rd);
      apb(0, 12'h004, 0);
      check("word one", word1, rd);
      if (rows[i].pwp != 8'hff) begin
        apb(0, 12'h010, 0);
        check("limit", rows[i].lim, rd);
      end
      flash_wr_addr <= rows[i].lim;
      @(posedge pclk);
      check("block at limit", rows[i].pwp != 8'hff, flash_wr_block);
      flash_wr_addr <= rows[i].lim + 1;
      @(posedge pclk);
      check("block above", 0, flash_wr_block);
      ticks(16 >> rows[i].w1[13:12]);
      $display("row %0d done", i);
    end
    apb(1, 12'h014, 0);
    check("ctrl error", 0, err);
    ticks(0);
    apb(1, 12'h014, 1);
    ticks(2);
    apb(1, 12'h000, 0);
    check("read only error", 1, err);
    apb(0, 12'h000, 0);
    check("word zero", word0, rd);
    apb(0, 12'h020, 0);
    check("unmapped error", 1, err);
    $display("register access done");
    boot(32'hffffffe6, 32'hffffcb5a, 0, 1);
    apb(0, 12'h008, 0);
    check("fault status", 32'hd, rd);
    $display("fault words done");
    give_verdict;
  end
endmodule
bind boot_config_word_decode boot_cfg_props chk (.pclk, .presetn,
  .cfg_rd_req, .cfg_rd_sel, .cfg_rd_valid, .code_protect, .flash_wr_req,
  .flash_wr_addr, .flash_wr_block, .cfg_ready_ff, .debugger_enable_ff,
  .debug_field_ff, .clock_out_enable_ff, .primary_osc_mode_ff,
  .initial_osc_select_ff, .protect_limit_ff, .protect_on_ff);
